// >>> hdl/spilcb_pkg.sv
/*
 * Constants for the serial block with selectable word length:
 * register byte offsets, field positions, reset values, states.
 * Assumes an APB slave with 32-bit data and 8-bit byte addresses.
 */
package spilcb_pkg;
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_BAUD  = 8'h08;
    localparam logic [7:0] OFF_STAT  = 8'h0C;
    localparam logic [7:0] OFF_DHI   = 8'h10;
    localparam logic [7:0] OFF_DLO   = 8'h14;
    localparam logic [7:0] OFF_MHI   = 8'h18;
    localparam logic [7:0] OFF_MLO   = 8'h1C;

    // first control register
    localparam int C1_LSBF = 0;
    localparam int C1_SELECT_OUTPUT_ENABLE = 1;
    localparam int C1_CLOCK_PHASE_BIT = 2;
    localparam int C1_CLOCK_POLARITY_BIT = 3;
    localparam int C1_MASTER_SELECT_BIT = 4;
    localparam int C1_SPE  = 5;
    // control_register_two
    localparam int C2_LEN  = 0;
    localparam int C2_MFEN = 1;
    // baud register: rate_field low, prescale_field high
    localparam int BD_RATE = 0;
    localparam int BD_PRE  = 4;
    // status_register
    localparam int ST_TEF  = 5;
    localparam int ST_MF   = 6;
    localparam int ST_RF   = 7;

    localparam logic [5:0] C1_RST = 6'h04;
    localparam logic [1:0] C2_RST = 2'h0;
    localparam logic [6:0] BD_RST = 7'h00;

    // serial clock edges per word
    localparam logic [5:0] EDGES_B8  = 6'h10;
    localparam logic [5:0] EDGES_B16 = 6'h20;

    typedef enum logic [1:0] {
        SPILCB_IDLE,
        SPILCB_LEAD,
        SPILCB_EDGES,
        SPILCB_TRAIL
    } spilcb_state_type;
endpackage : spilcb_pkg

// >>> hdl/spilcb_baud.sv
/*
 * Baud divider: prescaler then power-of-two stage, one pulse per
 * half bit period. Assumes run is low whenever no master transfer
 * is under way; counters are held at zero then.
 */
`timescale 1ns/1ps
module spilcb_baud
    import spilcb_pkg::*;
#(
    parameter int PRE_W  = 3,
    parameter int RATE_W = 3
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              run,
    input  wire logic [PRE_W-1:0]  prescale,
    input  wire logic [RATE_W-1:0] rate,
    output logic                   half_tick
);
    localparam int CNT_W = (1 << RATE_W) - 1;

    if (PRE_W < 1 || RATE_W < 1 || RATE_W > 4) begin : g_bad
        $error("spilcb_baud: unsupported field widths");
    end

    typedef struct packed {
        logic [PRE_W-1:0] pc;
        logic [CNT_W-1:0] rc;
        logic             tick;
    } spilcb_baud_type;

    spilcb_baud_type r;
    spilcb_baud_type n;
    logic [CNT_W-1:0] rc_last;

    always_comb begin
        n = r;
        n.tick = 1'b0;
        // half period is (prescale+1) * 2**rate bus clocks
        rc_last = CNT_W'((32'd1 << rate) - 32'd1);
        if (!run) begin
            n.pc = '0; // stopped outside transfers
            n.rc = '0;
        end else if (r.pc == prescale) begin
            n.pc = '0; // divide by prescale+1
            if (r.rc == rc_last) begin
                n.rc = '0; // further 2**(rate+1) per bit
                n.tick = 1'b1;
            end else begin
                n.rc = r.rc + 1'b1;
            end
        end else begin
            n.pc = r.pc + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign half_tick = r.tick;
endmodule : spilcb_baud

// >>> hdl/spilcb_core.sv
/*
 * Serial interface with 8/16-bit words, four clock formats, baud
 * divider, automatic select output and coherent byte buffers,
 * reached over APB. Assumes pins come from another domain and are
 * synchronised here; bus master on core_clk.
 */
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module spilcb_core
    import spilcb_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    input  wire logic        mosi_in,
    output logic             mosi_out,
    output logic             mosi_oe,
    input  wire logic        miso_in,
    output logic             miso_out,
    output logic             miso_oe,
    input  wire logic        ss_n_in,
    output logic             ss_n_out,
    output logic             ss_n_oe
);
    typedef struct packed {
        spilcb_state_type st;
        logic [5:0]  c1;
        logic [1:0]  c2;
        logic [6:0]  bd;
        logic [5:0]  k;
        logic [15:0] sh;
        logic        smp;
        logic        lvl;
        logic        ss;
        logic [15:0] tx;
        logic        txf;
        logic [15:0] rx;
        logic        rf;
        logic        mf;
        logic [15:0] mt;
        logic [15:0] dw;
        logic [1:0]  dwv;
        logic [15:0] mw;
        logic [1:0]  mwv;
        logic [15:0] dr;
        logic [1:0]  drv;
        logic [15:0] mr;
        logic [1:0]  mrv;
        logic [31:0] rd;
        logic [2:0]  sck_s;
        logic [1:0]  mosi_s;
        logic [1:0]  miso_s;
        logic [1:0]  ss_s;
    } spilcb_core_type;

    spilcb_core_type r;
    spilcb_core_type n;

    logic        tick;
    logic        run;
    logic        len16;
    logic        master_select_bit;
    logic        spe;
    logic        clock_phase_bit;
    logic        lsbf;
    logic        setup;
    logic        acc;
    logic        edge_ev;
    logic        smp_edge;
    logic        in_bit;
    logic        abort;
    logic        bsel;
    logic        done;
    logic [5:0]  kn;
    logic [5:0]  total;
    logic [15:0] word;
    logic [1:0]  nv;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
    endfunction : addr_hit

    // lsb-first enters at the top, msb-first at bit 0
    function automatic logic [15:0] shift_in(input logic [15:0] s,
            input logic b, input logic l16, input logic lf);
        if (lf) begin
            shift_in = l16 ? {b, s[15:1]} : {8'h00, b, s[7:1]};
        end else begin
            shift_in = l16 ? {s[14:0], b} : {8'h00, s[6:0], b};
        end
    endfunction : shift_in

    // read of byte b while v records bytes read since capture
    function automatic logic [1:0] latch_nxt(input logic [1:0] v,
            input logic b);
        if (v == 2'h0) begin
            latch_nxt = b ? 2'h2 : 2'h1;
        end else if (v[b]) begin
            latch_nxt = v;
        end else begin
            latch_nxt = 2'h0;
        end
    endfunction : latch_nxt

    spilcb_baud #(
        .PRE_W  (3),
        .RATE_W (3)
    ) u_baud (
        .core_clk  (core_clk),
        .rst       (rst),
        .run       (run),
        .prescale  (r.bd[BD_PRE+:3]),
        .rate      (r.bd[BD_RATE+:3]),
        .half_tick (tick)
    );

    assign len16 = r.c2[C2_LEN];
    assign master_select_bit  = r.c1[C1_MASTER_SELECT_BIT];
    assign spe   = r.c1[C1_SPE];
    assign clock_phase_bit  = r.c1[C1_CLOCK_PHASE_BIT];
    assign lsbf  = r.c1[C1_LSBF];
    assign run   = spe && master_select_bit && (r.st != SPILCB_IDLE);
    assign total = len16 ? EDGES_B16 : EDGES_B8;
    assign setup = psel && !penable;
    assign acc   = psel && penable;

    always_comb begin
        n = r;
        abort = 1'b0;
        edge_ev = 1'b0;
        smp_edge = 1'b0;
        done = 1'b0;
        kn = r.k + 6'h01;
        word = 16'h0000;
        nv = 2'h0;
        bsel = (paddr == OFF_DHI) || (paddr == OFF_MHI);
        in_bit = master_select_bit ? r.miso_s[1] : r.mosi_s[1];
        n.sck_s = {r.sck_s[1:0], sclk_in};
        n.mosi_s = {r.mosi_s[0], mosi_in};
        n.miso_s = {r.miso_s[0], miso_in};
        n.ss_s = {r.ss_s[0], ss_n_in};

        // read data is prepared in setup, shown in access
        if (setup && !pwrite) begin
            n.rd = 32'h0;
            case (paddr)
                OFF_CTRL1: n.rd[5:0] = r.c1;
                OFF_CTRL2: n.rd[1:0] = r.c2;
                OFF_BAUD:  n.rd[6:0] = r.bd;
                OFF_STAT: begin
                    n.rd[ST_RF] = r.rf;
                    n.rd[ST_MF] = r.mf;
                    n.rd[ST_TEF] = !r.txf;
                end
                OFF_DHI: if (len16) begin
                    n.rd[7:0] = (r.drv != 2'h0) ? r.dr[15:8]
                                                : r.rx[15:8];
                end
                OFF_DLO: begin
                    n.rd[7:0] = (len16 && r.drv != 2'h0) ? r.dr[7:0]
                                                         : r.rx[7:0];
                end
                OFF_MHI: if (len16) begin
                    n.rd[7:0] = (r.mrv != 2'h0) ? r.mr[15:8]
                                                : r.mt[15:8];
                end
                OFF_MLO: begin
                    n.rd[7:0] = (len16 && r.mrv != 2'h0) ? r.mr[7:0]
                                                         : r.mt[7:0];
                end
                default: n.rd = 32'h0;
            endcase
        end

        if (acc && pwrite) begin
            case (paddr)
                OFF_CTRL1: n.c1 = pwdata[5:0];
                OFF_CTRL2: begin
                    n.c2 = pwdata[1:0];
                    abort = master_select_bit && (pwdata[C2_LEN] != len16);
                end
                OFF_BAUD: n.bd = pwdata[6:0];
                OFF_STAT: if (pwdata[ST_MF]) begin
                    n.mf = 1'b0; // write one clears match flag
                end
                OFF_DHI, OFF_DLO: begin
                    if (len16) begin
                        nv = r.dwv | (bsel ? 2'h2 : 2'h1);
                        n.dw = bsel ? {pwdata[7:0], r.dw[7:0]}
                                    : {r.dw[15:8], pwdata[7:0]};
                        n.dwv = nv;
                        if (nv == 2'h3) begin
                            n.tx = n.dw; // both bytes as one word
                            n.txf = 1'b1;
                            n.dwv = 2'h0;
                        end
                    end else if (!bsel) begin
                        n.tx = {8'h00, pwdata[7:0]};
                        n.txf = 1'b1;
                    end
                end
                OFF_MHI, OFF_MLO: begin
                    if (len16) begin
                        nv = r.mwv | (bsel ? 2'h2 : 2'h1);
                        n.mw = bsel ? {pwdata[7:0], r.mw[7:0]}
                                    : {r.mw[15:8], pwdata[7:0]};
                        n.mwv = nv;
                        if (nv == 2'h3) begin
                            n.mt = n.mw;
                            n.mwv = 2'h0;
                        end
                    end else if (!bsel) begin
                        n.mt = {8'h00, pwdata[7:0]};
                    end
                end
                default: n.c1 = r.c1;
            endcase
        end

        if (acc && !pwrite) begin
            if (paddr == OFF_DHI || paddr == OFF_DLO) begin
                if (len16) begin
                    if (r.drv == 2'h0) begin
                        n.dr = r.rx; // hold until other byte
                    end
                    n.drv = latch_nxt(r.drv, bsel);
                    if (r.drv != 2'h0 && !r.drv[bsel]) begin
                        n.rf = 1'b0;
                    end
                end else if (!bsel) begin
                    n.rf = 1'b0;
                end
            end
            if ((paddr == OFF_MHI || paddr == OFF_MLO) && len16) begin
                if (r.mrv == 2'h0) begin
                    n.mr = r.mt;
                end
                n.mrv = latch_nxt(r.mrv, bsel);
            end
        end

        // master sequencing
        if (spe && master_select_bit) begin
            case (r.st)
                SPILCB_IDLE: if (r.txf) begin
                    n.sh = r.tx;
                    n.txf = 1'b0;
                    n.ss = 1'b0;
                    n.k = 6'h00;
                    n.lvl = 1'b0;
                    n.st = SPILCB_LEAD;
                end
                SPILCB_LEAD: if (tick) begin
                    edge_ev = 1'b1; // half period after select
                    n.st = SPILCB_EDGES;
                end
                SPILCB_EDGES: edge_ev = tick;
                SPILCB_TRAIL: if (tick) begin
                    n.ss = 1'b1;
                    n.st = SPILCB_IDLE;
                end
                default: n.st = SPILCB_IDLE;
            endcase
        end else begin
            n.st = SPILCB_IDLE;
            n.ss = 1'b1;
            n.lvl = 1'b0;
            if (!spe || r.ss_s[1]) begin
                n.k = 6'h00;
                if (spe && r.txf) begin
                    n.sh = r.tx; // first bit ready at select
                    n.txf = 1'b0;
                end
            end else if (r.sck_s[2] != r.sck_s[1]) begin
                edge_ev = 1'b1;
            end
        end

        if (edge_ev) begin
            n.k = kn;
            n.lvl = !r.lvl;
            smp_edge = clock_phase_bit ? !kn[0] : kn[0];
            if (smp_edge) begin
                n.smp = in_bit;
            end
            // phase 1 first edge only presents bit one
            if (!smp_edge && kn != 6'h01) begin
                n.sh = shift_in(r.sh, r.smp, len16, lsbf);
            end
            if (kn == total) begin
                done = 1'b1;
                word = shift_in(r.sh, smp_edge ? in_bit : r.smp,
                                len16, lsbf);
                n.rx = word;
                n.rf = 1'b1;
                if (word == r.mt) begin
                    n.mf = 1'b1;
                end
                // shifter left alone: data must not move on a sample edge
                n.k = 6'h00;
                if (master_select_bit) begin
                    n.st = SPILCB_TRAIL;
                end else if (r.txf) begin
                    n.sh = r.tx; // back to back, select held
                    n.txf = 1'b0;
                end
            end
        end

        if (abort) begin
            // transfer dropped, status cleared
            n.st = SPILCB_IDLE;
            n.ss = 1'b1;
            n.k = 6'h00;
            n.lvl = 1'b0;
            n.rf = 1'b0;
            n.mf = 1'b0;
            n.txf = 1'b0;
            n.dwv = 2'h0;
            n.drv = 2'h0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.c1 <= C1_RST;
            r.c2 <= C2_RST;
            r.bd <= BD_RST;
            r.ss <= 1'b1;
            r.ss_s <= 2'h3;
        end else begin
            r <= n;
        end
    end

    // data out end follows bit order and length
    assign mosi_out = lsbf ? r.sh[0] : (len16 ? r.sh[15] : r.sh[7]);
    assign miso_out = mosi_out;
    assign sclk_out = r.lvl ^ r.c1[C1_CLOCK_POLARITY_BIT];
    assign sclk_oe  = spe && master_select_bit;
    assign mosi_oe  = spe && master_select_bit;
    assign miso_oe  = spe && !master_select_bit && !r.ss_s[1];
    assign ss_n_out = r.ss;
    assign ss_n_oe  = spe && master_select_bit && r.c1[C1_SELECT_OUTPUT_ENABLE]
                      && r.c2[C2_MFEN];
    assign prdata   = r.rd;
    assign pready   = 1'b1;
    assign pslverr  = acc && !addr_hit(paddr);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_len_abort: assert property (
        (acc && pwrite && paddr == OFF_CTRL2 && master_select_bit
         && pwdata[C2_LEN] != len16)
        |=> (r.st == SPILCB_IDLE && !r.rf && !r.mf && r.ss))
        else $error("length change did not abort");

    chk_hi_zero: assert property (
        (setup && !pwrite && !len16
         && (paddr == OFF_DHI || paddr == OFF_MHI))
        |=> (prdata == 32'h0))
        else $error("high byte not zero in 8-bit mode");

    chk_rx_done: assert property (
        done |-> (kn == total) ##1 (r.rf && r.rx == $past(word)))
        else $error("word not moved to receive buffer");

    chk_div_stop: assert property (
        (!run ##1 !run) |-> !tick)
        else $error("divider ran outside transfer");

    chk_ss_idle: assert property (
        (r.st == SPILCB_IDLE) |-> ss_n_out)
        else $error("select low while idle");

    chk_sclk_idle: assert property (
        (master_select_bit && r.st == SPILCB_IDLE)
        |-> (sclk_out == r.c1[C1_CLOCK_POLARITY_BIT]))
        else $error("clock not at idle polarity");

    chk_tx_commit: assert property (
        (acc && pwrite && len16 && paddr == OFF_DHI
         && r.dwv == 2'h0 && !r.txf)
        |=> (!r.txf && r.dwv == 2'h2))
        else $error("half word reached transmit buffer");

    chk_rd_latch: assert property (
        (acc && !pwrite && len16 && paddr == OFF_DHI && r.drv == 2'h0)
        |=> (r.drv == 2'h2 && r.dr == $past(r.rx)))
        else $error("read did not capture both bytes");

    chk_ss_lead: assert property (
        (r.st == SPILCB_LEAD) |-> (!ss_n_out && r.k == 6'h00))
        else $error("select not low before first edge");
endmodule : spilcb_core

// >>> testbench/spilcb_slave_model.sv
/*
 * Behavioural slave at the far end of the serial pins: shifts
 * tx_word out and gathers rx_word by the clock-format rules.
 * Assumes the bench hands it phase, length and bit order.
 */
`timescale 1ns/1ps
module spilcb_slave_model (
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        ss_n,
    input  wire logic        clock_phase_bit,
    input  wire logic        len16,
    input  wire logic        lsbf,
    input  wire logic [15:0] tx_word,
    output logic             miso,
    output logic [15:0]      rx_word
);
    int cnt;

    // stream position to bit number, per length and order
    function automatic int pos(input int p);
        return lsbf ? p : (len16 ? 15 : 7) - p;
    endfunction : pos

    initial begin
        miso = 1'b0;
        rx_word = 16'h0000;
        cnt = 0;
    end

    // phase 0 drives bit one at select; phase 1 shows junk
    always @(negedge ss_n) begin
        cnt = 0;
        rx_word = 16'h0000;
        if (!clock_phase_bit)
            miso = tx_word[pos(0)];
        else
            miso = ~miso;
    end

    // released line has no pull, so the last bit is not left standing
    always @(posedge ss_n) // deselect ends the word
        miso = ~miso;

    // word length must agree with the master
    always @(sclk) begin
        if (ss_n === 1'b0) begin
            cnt = cnt + 1;
            if (cnt[0] != clock_phase_bit)
                rx_word[pos((cnt - 1) / 2)] = mosi;
            else if (cnt / 2 < (len16 ? 16 : 8))
                miso = tx_word[pos(cnt / 2)];
            else
                miso = ~miso;
        end
    end
endmodule : spilcb_slave_model

// >>> testbench/spilcb_core_bench.sv
/*
 * Self-checking bench: APB master tasks, one task per scenario,
 * behavioural slave on the serial pins.
 * Assumes the package register map and a 10 MHz bus clock.
 */
`timescale 1ns/1ps
module spilcb_core_bench;
    import spilcb_pkg::*;
    logic        core_clk, rst, psel, penable, pwrite, perr, sclk_q;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        pready, pslverr, sclk_out, sclk_oe, mosi_out, mosi_oe;
    logic        miso_out, miso_oe, ss_n_out, ss_n_oe, miso_w;
    logic        clock_phase_bit, len16, lsbf;
    logic [15:0] tx_word, rx_word;
    int          err_count, tests_run, edges, gap, last_gap;

    spilcb_core i_spilcb_core (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_out),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi_out),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
        .miso_out(miso_out), .miso_oe(miso_oe),
        .ss_n_in(ss_n_oe ? ss_n_out : 1'b1),
        .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe));

    spilcb_slave_model i_spilcb_slave_model (
        .sclk(sclk_out), .mosi(mosi_out), .ss_n(ss_n_out), .clock_phase_bit(clock_phase_bit),
        .len16(len16), .lsbf(lsbf), .tx_word(tx_word), .miso(miso_w),
        .rx_word(rx_word));

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    // edge count and spacing while selected
    always @(posedge core_clk) begin
        sclk_q <= sclk_out;
        gap <= gap + 1;
        if (ss_n_out === 1'b1)
            edges <= 0;
        if (ss_n_out === 1'b0 && sclk_out !== sclk_q) begin
            edges <= edges + 1;
            gap <= 1;
            if (edges > 0)
                last_gap <= gap;
        end
    end

    task automatic close_out;
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            close_out();
        end
        rdv = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // bounded wait for the select line to reach a level
    task automatic wait_ss(input logic v, input int lim);
        int n;
        for (n = 0; n < lim && ss_n_out !== v; n++)
            @(posedge core_clk);
        if (ss_n_out !== v) begin
            err_count++;
            close_out();
        end
    endtask : wait_ss

    task automatic t_reset;
        rd(OFF_CTRL1);
        chk(rdv, 32'h04);
        rd(OFF_STAT);
        chk(rdv, 32'h20);
        rd(8'h20);
        chk(rdv, 32'h0);
        chk(perr, 1'b1);
        chk(ss_n_out, 1'b1);
    endtask : t_reset

    task automatic t_len8;
        wr(OFF_CTRL2, 32'h2);
        wr(OFF_DHI, 32'hAB);
        rd(OFF_DHI);
        chk(rdv, 32'h0);
        wr(OFF_MHI, 32'hCD);
        rd(OFF_MHI);
        chk(rdv, 32'h0);
    endtask : t_len8

    task automatic xfer(input logic l16, input logic ph, input logic pol,
                        input logic lb, input logic [2:0] pre,
                        input logic [2:0] rt, input logic [15:0] dv,
                        input logic [15:0] pt);
        int h;
        h = (pre + 1) * (2 ** rt);
        clock_phase_bit = ph;
        len16 = l16;
        lsbf = lb;
        tx_word = pt;
        wr(OFF_BAUD, {25'h0, pre, 1'b0, rt});
        wr(OFF_CTRL2, {30'h0, 1'b1, l16});
        wr(OFF_CTRL1, {26'h0, 2'b11, pol, ph, 1'b1, lb});
        rd(OFF_STAT);
        chk(rdv[ST_TEF], 1'b1);
        chk({sclk_oe, ss_n_oe, sclk_out}, {2'b11, pol});
        if (l16) begin
            wr(OFF_DHI, {24'h0, dv[15:8]});
            repeat (2) @(posedge core_clk);
            chk(ss_n_out, 1'b1);
        end
        wr(OFF_DLO, {24'h0, dv[7:0]});
        wait_ss(1'b0, 4);
        wait_ss(1'b1, 3000);
        chk(edges, l16 ? 32 : 16);
        chk(last_gap, h);
        chk(rx_word, l16 ? dv : {8'h0, dv[7:0]});
        rd(OFF_STAT);
        chk(rdv[ST_RF], 1'b1);
        rd(OFF_DHI);
        chk(rdv, {24'h0, l16 ? pt[15:8] : 8'h00});
        rd(OFF_DLO);
        chk(rdv, {24'h0, pt[7:0]});
        chk(sclk_out, pol);
    endtask : xfer

    task automatic t_match;
        wr(OFF_CTRL2, 32'h3);
        wr(OFF_MHI, 32'h12);
        rd(OFF_MHI);
        chk(rdv, 32'h0);
        wr(OFF_MLO, 32'h34);
        rd(OFF_MLO);
        chk(rdv, 32'h0); // capture from the high read still holds
        rd(OFF_MHI);
        chk(rdv, 32'h12);
        rd(OFF_MLO);
        chk(rdv, 32'h34);
    endtask : t_match

    // slow word cut short by a length change mid-frame
    task automatic t_abort;
        wr(OFF_BAUD, 32'h77);
        wr(OFF_DHI, 32'h5A);
        wr(OFF_DLO, 32'hA5);
        wait_ss(1'b0, 4);
        wr(OFF_CTRL2, 32'h2);
        wait_ss(1'b1, 4);
        rd(OFF_STAT);
        chk(rdv, 32'h20);
    endtask : t_abort

    task automatic t_slave;
        wr(OFF_CTRL1, 32'h20); // length left alone as slave
        @(posedge core_clk);
        chk({sclk_oe, mosi_oe, miso_oe, ss_n_oe}, 4'h0);
    endtask : t_slave

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {err_count, tests_run} = '0;
        {clock_phase_bit, len16, lsbf, tx_word} = '0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_len8();
        xfer(1'b0, 1'b1, 1'b0, 1'b0, 3'd1, 3'd1, 16'h00A5, 16'h003C);
        xfer(1'b0, 1'b0, 1'b1, 1'b1, 3'd2, 3'd1, 16'h0096, 16'h00C3);
        t_match();
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 3'd0, 3'd2, 16'hBEEF, 16'h1234);
        rd(OFF_STAT);
        chk(rdv[ST_MF], 1'b1);
        xfer(1'b1, 1'b1, 1'b1, 1'b1, 3'd1, 3'd1, 16'h8001, 16'h1234);
        t_abort();
        t_slave();
        close_out();
    end
endmodule : spilcb_core_bench
